//--- gdc_pkg.sv
// Package with register map, field layout, resets and encodings
package gdc_pkg;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned ADDR_W   = 12;
  localparam int unsigned REG_W    = 8;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_PIN_DATA   = 10'h000;
  localparam logic [9:0] IDX_IRQ_ENABLE = 10'h001;
  localparam logic [9:0] IDX_DM_LOW     = 10'h002;
  localparam logic [9:0] IDX_DM_HIGH    = 10'h003;
  localparam logic [9:0] IDX_IRQ_MASK   = 10'h004;
  localparam logic [9:0] IDX_CFG_ONE    = 10'h0dc;
  localparam logic [9:0] IDX_CFG_TWO    = 10'h0de;

  // Field positions in io_config_one
  localparam int unsigned CFG1_BOOST_BIT  = 7;
  localparam int unsigned CFG1_RANGE_LSB  = 4;
  localparam int unsigned CFG1_THRS_BIT   = 3;
  localparam int unsigned CFG1_SCLK_BIT   = 2;
  localparam int unsigned CFG1_REGEN_BIT  = 1;
  localparam int unsigned CFG1_MODE_BIT   = 0;
  // Field positions in io_config_two
  localparam int unsigned CFG2_LEVEL_LSB  = 3;
  localparam int unsigned CFG2_PUMP_LSB   = 0;
  // Global pin interrupt bit in irq_mask_zero
  localparam int unsigned MASK_GPIO_BIT   = 0;

  // Writable bits; reserved bits read as zero
  localparam logic [7:0] CFG1_WMASK = 8'hbf;
  localparam logic [7:0] CFG2_WMASK = 8'h3b;
  localparam logic [7:0] MASK_WMASK = 8'h01;

  // Reset values
  localparam logic [7:0] RST_PIN_DATA = 8'h00;
  localparam logic [7:0] RST_IRQ_EN   = 8'h00;
  localparam logic [7:0] RST_DM_LOW   = 8'h00;
  localparam logic [7:0] RST_DM_HIGH  = 8'hff;
  localparam logic [7:0] RST_IRQ_MASK = 8'h00;
  localparam logic [7:0] RST_CFG_ONE  = 8'h00;
  localparam logic [7:0] RST_CFG_TWO  = 8'h00;

  // Pin drive select codes {high bit, low bit}
  typedef enum logic [1:0] {
    DRV_PULLUP = 2'h0,
    DRV_STRONG = 2'h1,
    DRV_ANALOG = 2'h2,
    DRV_OPEN   = 2'h3
  } gdc_drive_e;

  // Port 1 regulator level, one-hot
  typedef enum logic [2:0] {
    LVL_TOP = 3'h1,
    LVL_MID = 3'h2,
    LVL_LOW = 3'h4
  } gdc_level_e;

  // Bus slave states, one-hot
  typedef enum logic [1:0] {
    APB_IDLE = 2'h1,
    APB_ACK  = 2'h2
  } gdc_apb_e;
endpackage : gdc_pkg

//--- gdc_pin_if.sv
// Interface between register logic and per-pin drive decoder
`timescale 1ns/1ps
interface gdc_pin_if #(parameter int unsigned NPINS = 8);
  logic [NPINS-1:0] dm_low;
  logic [NPINS-1:0] dm_high;
  logic [NPINS-1:0] out_val;
  logic [NPINS-1:0] oe_n;
  logic [NPINS-1:0] pu_en;
  logic [NPINS-1:0] in_en;
  modport cfg (output dm_low, dm_high, out_val,
               input  oe_n, pu_en, in_en);
  modport pin (input  dm_low, dm_high, out_val,
               output oe_n, pu_en, in_en);
endinterface : gdc_pin_if

//--- gdc_pin_ctrl.sv
// Per-pin decode of drive select into enable controls
`timescale 1ns/1ps
module gdc_pin_ctrl #(
  parameter int unsigned NPINS = 8
) (
  gdc_pin_if.pin pins
);
  // Returns {oe_n, pu_en, in_en} for one pin
  function automatic logic [2:0] drv_decode(
    input logic [1:0] code,
    input logic       val
  );
    logic [2:0] res;
    res = 3'h5;
    case (code)
      gdc_pkg::DRV_PULLUP: res = {val, val, 1'b1};  // [RQ3] [RQ21]
      gdc_pkg::DRV_STRONG: res = 3'h1;              // [RQ4] [RQ21]
      gdc_pkg::DRV_ANALOG: res = 3'h4;              // [RQ5] [RQ21]
      gdc_pkg::DRV_OPEN:   res = {val, 2'h1};       // [RQ6] [RQ21]
      default:             res = 3'h4;
    endcase
    return res;
  endfunction : drv_decode

  for (genvar i = 0; i < NPINS; i++) begin : g_pin
    logic [2:0] dec;
    always_comb begin
      // Both bits of a pin share its bit position
      dec = drv_decode({pins.dm_high[i], pins.dm_low[i]},
                       pins.out_val[i]);  // [RQ1] [RQ2]
    end
    assign pins.oe_n[i]  = dec[2];
    assign pins.pu_en[i] = dec[1];
    assign pins.in_en[i] = dec[0];
  end
endmodule : gdc_pin_ctrl

//--- gdc_irq_eval.sv
// Per-pin interrupt condition for the shared interrupt line
`timescale 1ns/1ps
module gdc_irq_eval #(
  parameter int unsigned NPINS = 8
) (
  input  wire logic [NPINS-1:0] pin_lvl,
  input  wire logic [NPINS-1:0] last_read,
  input  wire logic [NPINS-1:0] pin_irq_enable,
  input  wire logic             shared_irq_mode,
  input  wire logic             gpio_mask,
  output logic                  irq_hit
);
  logic [NPINS-1:0] hit;

  for (genvar i = 0; i < NPINS; i++) begin : g_hit
    always_comb begin
      if (shared_irq_mode) begin
        hit[i] = pin_irq_enable[i] &
                 (pin_lvl[i] ^ last_read[i]);  // [RQ19]
      end else begin
        hit[i] = pin_irq_enable[i] & ~pin_lvl[i];  // [RQ18]
      end
    end
  end

  assign irq_hit = gpio_mask & (|hit);  // [RQ14]
endmodule : gdc_irq_eval

//--- gdc_gpio_cfg.sv
// Pin drive modes, port I/O configuration and APB register file
//
// Contract
// RQ1: Each pin's drive mode is two bits, one per drive-mode register.
// RQ2: A pin's mode bits sit at its own bit position in both registers.
// RQ3: Code 00 drives strongly low and pulls high through a resistor.
// RQ4: Code 01 drives strongly high and low from the output value.
// RQ5: Code 10 leaves pin undriven, input off, reads zero, no interrupt; the code asserts it in mode 0 for an enabled pin, which reads low.
// RQ6: Code 11 drives low only, floats when high, input stays on.
// RQ7: Reset sets every upper drive-mode register to all ones.
// RQ8: Software uses code 11 with data high to read analogue pins.
// RQ9: Config one bit 7 raises high-level output drive strength.
// RQ10: Config one bits 5:4 pick regulator level: 0x top, 10 low, 11 mid.
// RQ11: Config one bit 3 selects reduced port 1 input threshold.
// RQ12: Config one bit 2 routes serial clock to pin 0, else pin 3.
// RQ13: Config one bit 1 enables the port 1 output regulator.
// RQ14: Config one bit 0 sets shared irq mode; enable and mask gate.
// RQ15: Config one is read-write and resets to zero.
// RQ16: Config two bits 5:3 select regulated supply level, eight steps.
// RQ17: Config two bits 1:0 select pump clock, at most 12 MHz.
// RQ18: Mode 0: an enabled pin asserts the interrupt while low.
// RQ19: Mode 1: an enabled pin asserts while unequal to last read.
// RQ20: Port data reads return pin levels, not stored output bits.
// RQ21: Drive bits decode to output, pull-up and input enables.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module gdc_gpio_cfg #(
  parameter int unsigned NPINS = 8
) (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [gdc_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [gdc_pkg::DATA_W-1:0]   pwdata,
  input  wire logic [3:0]                   pstrb,
  output logic      [gdc_pkg::DATA_W-1:0]   prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic [NPINS-1:0]             pin_in,
  output logic      [NPINS-1:0]             pin_out,
  output logic      [NPINS-1:0]             pin_oe_n,
  output logic      [NPINS-1:0]             pin_pu_en,
  output logic      [NPINS-1:0]             pin_in_en,
  input  wire logic                         spi_clk_alt,
  input  wire logic                         spi_clk_en,
  output logic                              gpio_irq_n,
  output logic                              high_drive_boost,
  output logic      [2:0]                   p1_level_sel,
  output logic                              reduced_input_threshold,
  output logic                              serial_clock_pin_select,
  output logic                              p1_reg_en,
  output logic      [2:0]                   reg_supply_level,
  output logic      [1:0]                   pump_clk_sel
);
  if (NPINS < 4 || NPINS > gdc_pkg::REG_W) begin : g_bad_npins
    $error("NPINS must lie between 4 and 8");
  end

  // Register storage
  logic [NPINS-1:0]           pin_data_ff;
  logic [NPINS-1:0]           irq_enable_ff;
  logic [NPINS-1:0]           dm_low_ff;
  logic [NPINS-1:0]           dm_high_ff;
  logic [gdc_pkg::REG_W-1:0]  irq_mask_ff;
  logic [gdc_pkg::REG_W-1:0]  cfg_one_ff;
  logic [gdc_pkg::REG_W-1:0]  cfg_two_ff;
  logic [NPINS-1:0]           last_read_ff;

  // Bus slave state
  gdc_pkg::gdc_apb_e          apb_ff;
  gdc_pkg::gdc_apb_e          nxt_apb;
  logic [gdc_pkg::DATA_W-1:0] prdata_ff;
  logic [gdc_pkg::DATA_W-1:0] nxt_prdata;
  logic                       pready_ff;
  logic                       pslverr_ff;
  logic                       nxt_pslverr;

  // Output flops
  logic [NPINS-1:0]           pin_out_ff;
  logic [NPINS-1:0]           pin_oe_n_ff;
  logic [NPINS-1:0]           pin_pu_en_ff;
  logic [NPINS-1:0]           pin_in_en_ff;
  logic                       irq_n_ff;
  logic [2:0]                 level_ff;
  logic [2:0]                 nxt_level;

  // Decode and strobes
  logic                       setup_cyc;
  logic                       done_cyc;
  logic                       wr_done;
  logic                       rd_done;
  logic                       lane0;
  logic [9:0]                 idx;
  logic                       addr_ok;
  logic [gdc_pkg::REG_W-1:0]  wbyte;
  logic [NPINS-1:0]           pin_lvl;
  logic [NPINS-1:0]           drive_val;
  logic                       irq_hit;

  gdc_pin_if #(.NPINS(NPINS)) pins ();

  // Address index of a word access; true when it hits a register
  function automatic logic is_mapped(input logic [9:0] i);
    case (i)
      gdc_pkg::IDX_PIN_DATA,
      gdc_pkg::IDX_IRQ_ENABLE,
      gdc_pkg::IDX_DM_LOW,
      gdc_pkg::IDX_DM_HIGH,
      gdc_pkg::IDX_IRQ_MASK,
      gdc_pkg::IDX_CFG_ONE,
      gdc_pkg::IDX_CFG_TWO: is_mapped = 1'b1;
      default:              is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  // Narrow pin vector placed in a register byte
  function automatic logic [gdc_pkg::REG_W-1:0] widen(
    input logic [NPINS-1:0] v
  );
    widen = '0;
    widen[NPINS-1:0] = v;
  endfunction : widen

  assign idx       = paddr[11:2];
  assign addr_ok   = is_mapped(idx) && (paddr[1:0] == 2'h0);
  assign setup_cyc = psel && !penable && (apb_ff == gdc_pkg::APB_IDLE);
  assign done_cyc  = psel && penable && pready_ff;
  assign wr_done   = done_cyc && pwrite && !pslverr_ff;
  assign rd_done   = done_cyc && !pwrite && !pslverr_ff;
  assign lane0     = pstrb[0];
  assign wbyte     = pwdata[gdc_pkg::REG_W-1:0];

  // Analogue pins read as zero since their input is off
  assign pin_lvl = pin_in & pins.in_en;  // [RQ5] [RQ20]

  // Serial clock bypass onto pin 0 or pin 3 of the port
  always_comb begin
    drive_val = pin_data_ff;
    if (spi_clk_en) begin
      if (cfg_one_ff[gdc_pkg::CFG1_SCLK_BIT]) begin
        drive_val[0] = spi_clk_alt;  // [RQ12]
      end else begin
        drive_val[3] = spi_clk_alt;  // [RQ12]
      end
    end
  end

  assign pins.dm_low  = dm_low_ff;
  assign pins.dm_high = dm_high_ff;
  assign pins.out_val = drive_val;

  gdc_pin_ctrl #(.NPINS(NPINS)) u_pin_ctrl (
    .pins (pins.pin)
  );

  gdc_irq_eval #(.NPINS(NPINS)) u_irq_eval (
    .pin_lvl         (pin_lvl),
    .last_read       (last_read_ff),
    .pin_irq_enable  (irq_enable_ff),
    .shared_irq_mode (cfg_one_ff[gdc_pkg::CFG1_MODE_BIT]),
    .gpio_mask       (irq_mask_ff[gdc_pkg::MASK_GPIO_BIT]),
    .irq_hit         (irq_hit)
  );

  // Bus state: answer in the first access cycle
  always_comb begin
    nxt_apb = apb_ff;
    case (apb_ff)
      gdc_pkg::APB_IDLE: begin
        if (setup_cyc) begin
          nxt_apb = gdc_pkg::APB_ACK;
        end
      end
      gdc_pkg::APB_ACK: begin
        nxt_apb = gdc_pkg::APB_IDLE;
      end
      default: nxt_apb = gdc_pkg::APB_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_ff <= gdc_pkg::APB_IDLE;
    end else begin
      apb_ff <= nxt_apb;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= setup_cyc;
    end
  end

  // Read mux, sampled in the setup cycle
  always_comb begin
    nxt_prdata  = '0;
    nxt_pslverr = !addr_ok;
    case (idx)
      gdc_pkg::IDX_PIN_DATA:
        nxt_prdata[7:0] = widen(pin_lvl);  // [RQ20]
      gdc_pkg::IDX_IRQ_ENABLE:
        nxt_prdata[7:0] = widen(irq_enable_ff);
      gdc_pkg::IDX_DM_LOW:
        nxt_prdata[7:0] = widen(dm_low_ff);
      gdc_pkg::IDX_DM_HIGH:
        nxt_prdata[7:0] = widen(dm_high_ff);
      gdc_pkg::IDX_IRQ_MASK:
        nxt_prdata[7:0] = irq_mask_ff;
      gdc_pkg::IDX_CFG_ONE:
        nxt_prdata[7:0] = cfg_one_ff;  // [RQ15]
      gdc_pkg::IDX_CFG_TWO:
        nxt_prdata[7:0] = cfg_two_ff;
      default:
        nxt_prdata = '0;
    endcase
    if (pwrite || !addr_ok) begin
      nxt_prdata = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= '0;
      pslverr_ff <= 1'b0;
    end else if (setup_cyc) begin
      prdata_ff  <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end else if (done_cyc) begin
      prdata_ff  <= '0;
      pslverr_ff <= 1'b0;
    end
  end

  // Writable registers, byte lane 0 only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_data_ff <= gdc_pkg::RST_PIN_DATA[NPINS-1:0];
    end else if (wr_done && lane0 && idx == gdc_pkg::IDX_PIN_DATA) begin
      pin_data_ff <= wbyte[NPINS-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable_ff <= gdc_pkg::RST_IRQ_EN[NPINS-1:0];
    end else if (wr_done && lane0 &&
                 idx == gdc_pkg::IDX_IRQ_ENABLE) begin
      irq_enable_ff <= wbyte[NPINS-1:0];  // [RQ14]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dm_low_ff <= gdc_pkg::RST_DM_LOW[NPINS-1:0];
    end else if (wr_done && lane0 && idx == gdc_pkg::IDX_DM_LOW) begin
      dm_low_ff <= wbyte[NPINS-1:0];  // [RQ1]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dm_high_ff <= gdc_pkg::RST_DM_HIGH[NPINS-1:0];  // [RQ7]
    end else if (wr_done && lane0 && idx == gdc_pkg::IDX_DM_HIGH) begin
      dm_high_ff <= wbyte[NPINS-1:0];  // [RQ1]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_ff <= gdc_pkg::RST_IRQ_MASK;
    end else if (wr_done && lane0 && idx == gdc_pkg::IDX_IRQ_MASK) begin
      irq_mask_ff <= wbyte & gdc_pkg::MASK_WMASK;  // [RQ14]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_one_ff <= gdc_pkg::RST_CFG_ONE;  // [RQ15]
    end else if (wr_done && lane0 && idx == gdc_pkg::IDX_CFG_ONE) begin
      cfg_one_ff <= wbyte & gdc_pkg::CFG1_WMASK;  // [RQ15]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_two_ff <= gdc_pkg::RST_CFG_TWO;
    end else if (wr_done && lane0 && idx == gdc_pkg::IDX_CFG_TWO) begin
      cfg_two_ff <= wbyte & gdc_pkg::CFG2_WMASK;  // [RQ16] [RQ17]
    end
  end

  // Levels returned by the last port data read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_read_ff <= '0;
    end else if (rd_done && idx == gdc_pkg::IDX_PIN_DATA) begin
      last_read_ff <= prdata_ff[NPINS-1:0];  // [RQ19]
    end
  end

  // Pin controls registered for the pads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_ff   <= '0;
      pin_oe_n_ff  <= '1;
      pin_pu_en_ff <= '0;
      pin_in_en_ff <= '0;
    end else begin
      pin_out_ff   <= drive_val;      // [RQ4]
      pin_oe_n_ff  <= pins.oe_n;      // [RQ21]
      pin_pu_en_ff <= pins.pu_en;     // [RQ21]
      pin_in_en_ff <= pins.in_en;     // [RQ21]
    end
  end

  // Shared interrupt line, active low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_n_ff <= 1'b1;
    end else begin
      irq_n_ff <= !irq_hit;  // [RQ18] [RQ19]
    end
  end

  // Port 1 regulator level decode
  always_comb begin
    case (cfg_one_ff[gdc_pkg::CFG1_RANGE_LSB +: 2])
      2'h0, 2'h1: nxt_level = gdc_pkg::LVL_TOP;  // [RQ10]
      2'h2:       nxt_level = gdc_pkg::LVL_LOW;  // [RQ10]
      2'h3:       nxt_level = gdc_pkg::LVL_MID;  // [RQ10]
      default:    nxt_level = gdc_pkg::LVL_TOP;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_ff <= gdc_pkg::LVL_TOP;
    end else begin
      level_ff <= nxt_level;
    end
  end

  assign prdata    = prdata_ff;
  assign pready    = pready_ff;
  assign pslverr   = pslverr_ff;
  assign pin_out   = pin_out_ff;
  assign pin_oe_n  = pin_oe_n_ff;
  assign pin_pu_en = pin_pu_en_ff;
  assign pin_in_en = pin_in_en_ff;
  assign gpio_irq_n = irq_n_ff;
  assign p1_level_sel = level_ff;

  // Config fields go straight from their register bits
  assign high_drive_boost =
    cfg_one_ff[gdc_pkg::CFG1_BOOST_BIT];  // [RQ9]
  assign reduced_input_threshold =
    cfg_one_ff[gdc_pkg::CFG1_THRS_BIT];  // [RQ11]
  assign serial_clock_pin_select =
    cfg_one_ff[gdc_pkg::CFG1_SCLK_BIT];  // [RQ12]
  assign p1_reg_en =
    cfg_one_ff[gdc_pkg::CFG1_REGEN_BIT];  // [RQ13]
  assign reg_supply_level =
    cfg_two_ff[gdc_pkg::CFG2_LEVEL_LSB +: 3];  // [RQ16]
  assign pump_clk_sel =
    cfg_two_ff[gdc_pkg::CFG2_PUMP_LSB +: 2];  // [RQ17]
endmodule : gdc_gpio_cfg

//--- gdc_cfg_properties.sv
// Port-level checker for the gpio drive and io configuration block
`timescale 1ns/1ps
module gdc_cfg_properties #(
  parameter int unsigned NPINS = 8
) (
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [gdc_pkg::ADDR_W-1:0] paddr,
  input wire logic [gdc_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0]                 pstrb,
  input wire logic                       pready,
  input wire logic [NPINS-1:0]           pin_oe_n,
  input wire logic [NPINS-1:0]           pin_pu_en,
  input wire logic [NPINS-1:0]           pin_in_en,
  input wire logic                       gpio_irq_n,
  input wire logic                       high_drive_boost,
  input wire logic [2:0]                 p1_level_sel,
  input wire logic                       reduced_input_threshold,
  input wire logic                       serial_clock_pin_select,
  input wire logic                       p1_reg_en,
  input wire logic [2:0]                 reg_supply_level,
  input wire logic [1:0]                 pump_clk_sel
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_ok;
  assign wr_ok = psel & penable & pready & pwrite & pstrb[0];
  function automatic logic [2:0] lvl(input logic [1:0] r);
    return (r == 2'h2) ? 3'h4 : ((r == 2'h3) ? 3'h2 : 3'h1);
  endfunction : lvl

  a_setup_answer: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready missing or longer than one cycle");
  a_reset_analog: assert property ($rose(presetn) |->
      &pin_oe_n && pin_in_en == '0 && pin_pu_en == '0)
    else $error("pins not analogue after reset");
  a_reset_config: assert property ($rose(presetn) |-> gpio_irq_n &&
      {high_drive_boost, p1_level_sel, reduced_input_threshold,
       serial_clock_pin_select, p1_reg_en} == 7'h08)
    else $error("config outputs not at reset values");
  a_analog_quiet: assert property ((~pin_in_en & (~pin_oe_n | pin_pu_en)) == '0)
    else $error("input-off pin is driven or pulled");
  a_pullup_high: assert property ((pin_pu_en & ~(pin_oe_n & pin_in_en)) == '0)
    else $error("pull-up active while driven or input off");
  a_cfg1_boost: assert property (wr_ok && paddr == 12'h370 |->
      ##2 high_drive_boost == $past(pwdata[7], 2))
    else $error("boost output does not follow write");
  a_cfg1_level: assert property (wr_ok && paddr == 12'h370 |->
      ##2 p1_level_sel == lvl($past(pwdata[5:4], 2)))
    else $error("level select decoded wrongly");
  a_cfg1_misc: assert property (wr_ok && paddr == 12'h370 |->
      ##2 {reduced_input_threshold, serial_clock_pin_select, p1_reg_en}
      == $past(pwdata[3:1], 2))
    else $error("threshold, clock select or enable wrong");
  a_cfg2_fields: assert property (wr_ok && paddr == 12'h378 |->
      ##2 reg_supply_level == $past(pwdata[5:3], 2)
      && pump_clk_sel == $past(pwdata[1:0], 2))
    else $error("supply level or pump clock wrong");
  a_mask_release: assert property (wr_ok && paddr == 12'h010 && !pwdata[0] |->
      ##[1:3] gpio_irq_n)
    else $error("interrupt held while masked");
endmodule : gdc_cfg_properties

bind gdc_gpio_cfg gdc_cfg_properties #(.NPINS(NPINS)) u_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
  .pready, .pin_oe_n, .pin_pu_en, .pin_in_en, .gpio_irq_n,
  .high_drive_boost, .p1_level_sel, .reduced_input_threshold,
  .serial_clock_pin_select, .p1_reg_en, .reg_supply_level, .pump_clk_sel
);

//--- gdc_pad_model.sv
// Behavioural pads and external loads on the port pins
`timescale 1ns/1ps
module gdc_pad_model #(
  parameter int unsigned NPINS = 8
) (
  input  wire logic             pclk,
  input  wire logic [NPINS-1:0] pin_out,
  input  wire logic [NPINS-1:0] pin_oe_n,
  input  wire logic [NPINS-1:0] pin_pu_en,
  input  wire logic [NPINS-1:0] ext_en,
  input  wire logic [NPINS-1:0] ext_val,
  output logic      [NPINS-1:0] pin_in
);
  logic [NPINS-1:0] float_ff = '0;
  // Undriven pads wander, so a read of one never settles
  always @(posedge pclk) begin
    float_ff <= ~float_ff;
  end
  // A strong load beats the pad driver, then driver, then pull-up
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      if (ext_en[i])
        pin_in[i] = ext_val[i];
      else if (!pin_oe_n[i])
        pin_in[i] = pin_out[i];
      else if (pin_pu_en[i])
        pin_in[i] = 1'b1;
      else
        pin_in[i] = float_ff[i];
    end
  end
endmodule : gdc_pad_model

//--- gdc_tb.sv
// Self-checking bench for the gpio drive and io configuration block
`timescale 1ns/1ps
module tb;
  localparam logic [11:0] A_DATA = {gdc_pkg::IDX_PIN_DATA, 2'b00};
  localparam logic [11:0] A_EN   = {gdc_pkg::IDX_IRQ_ENABLE, 2'b00};
  localparam logic [11:0] A_DML  = {gdc_pkg::IDX_DM_LOW, 2'b00};
  localparam logic [11:0] A_DMH  = {gdc_pkg::IDX_DM_HIGH, 2'b00};
  localparam logic [11:0] A_MSK  = {gdc_pkg::IDX_IRQ_MASK, 2'b00};
  localparam logic [11:0] A_C1   = {gdc_pkg::IDX_CFG_ONE, 2'b00};
  localparam logic [11:0] A_C2   = {gdc_pkg::IDX_CFG_TWO, 2'b00};
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic        pready, pslverr, err, spi_clk_alt, spi_clk_en, gpio_irq_n;
  logic [7:0]  pin_in, pin_out, pin_oe_n, pin_pu_en, pin_in_en;
  logic [7:0]  ext_en, ext_val, v;
  logic        high_drive_boost, reduced_input_threshold;
  logic        serial_clock_pin_select, p1_reg_en;
  logic [2:0]  p1_level_sel, reg_supply_level;
  logic [1:0]  pump_clk_sel;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  logic [11:0] ra[7] = '{A_DATA, A_EN, A_DML, A_DMH, A_MSK, A_C1, A_C2};
  logic [7:0]  rv[7] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
  logic [2:0]  lv[4] = '{3'h1, 3'h1, 3'h4, 3'h2};

  gdc_gpio_cfg #(.NPINS(8)) u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe_n, .pin_pu_en,
    .pin_in_en, .spi_clk_alt, .spi_clk_en, .gpio_irq_n, .high_drive_boost,
    .p1_level_sel, .reduced_input_threshold, .serial_clock_pin_select,
    .p1_reg_en, .reg_supply_level, .pump_clk_sel
  );
  gdc_pad_model #(.NPINS(8)) u_pads (
    .pclk, .pin_out, .pin_oe_n, .pin_pu_en, .ext_en, .ext_val, .pin_in
  );

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n == 20)
      n_mismatch++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic irq_is(input logic e);
    int n;
    n = 0;
    while (gpio_irq_n !== e && n < 8) begin
      @(posedge pclk);
      n++;
    end
    chk("irq_n", {31'h0, e}, {31'h0, gpio_irq_n});
  endtask : irq_is

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  initial begin
    #200000;
    n_mismatch++;
    give_verdict();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hf;
    spi_clk_alt = 1'b0;
    spi_clk_en = 1'b0;
    ext_en = 8'hff;
    ext_val = 8'hff;
    do_reset();
    chk("oe_n", 32'hff, {24'h0, pin_oe_n});
    for (int i = 0; i < 7; i++) begin
      xfer(1'b0, ra[i], '0);
      chk("reset reg", {24'h0, rv[i]}, rd);
    end
    xfer(1'b0, 12'h020, '0);
    chk("unmapped err", 32'h1, {31'h0, err});
    $display("test reset finished");
    ext_en <= 8'h00;
    xfer(1'b1, A_DATA, 32'haa);
    xfer(1'b1, A_DML, 32'hcc);
    xfer(1'b1, A_DMH, 32'hf0);
    repeat (3) @(posedge pclk);
    chk("pin_out", 32'haa, {24'h0, pin_out});
    chk("oe_n", 32'hb2, {24'h0, pin_oe_n});
    chk("pu_en", 32'h02, {24'h0, pin_pu_en});
    chk("in_en", 32'hcf, {24'h0, pin_in_en});
    ext_en <= 8'ha4;
    ext_val <= 8'ha4;
    repeat (3) @(posedge pclk);
    xfer(1'b0, A_DATA, '0);
    chk("pin read", 32'h8e, rd);
    ext_val <= 8'h24;
    repeat (3) @(posedge pclk);
    xfer(1'b0, A_DATA, '0);
    chk("pin read", 32'h0e, rd);
    $display("test drive finished");
    for (int k = 0; k < 4; k++) begin
      v = {k[0], 1'b1, k[1:0], k[1], k[0], ~k[0], 1'b0};
      xfer(1'b1, A_C1, {24'h0, v});
      xfer(1'b0, A_C1, '0);
      chk("cfg one", {24'h0, v & 8'hbf}, rd);
      chk("cfg one out", {25'h0, v[7], lv[k], v[3:1]},
          {25'h0, high_drive_boost, p1_level_sel, reduced_input_threshold,
           serial_clock_pin_select, p1_reg_en});
    end
    for (int k = 0; k < 8; k++) begin
      v = {2'b11, k[2:0], 1'b1, k[1:0]};
      xfer(1'b1, A_C2, {24'h0, v});
      xfer(1'b0, A_C2, '0);
      chk("cfg two", {24'h0, v & 8'h3b}, rd);
      chk("supply", {27'h0, k[2:0], k[1:0]},
          {27'h0, reg_supply_level, pump_clk_sel});
    end
    pstrb <= 4'he;
    xfer(1'b1, A_C2, '0);
    pstrb <= 4'hf;
    xfer(1'b0, A_C2, '0);
    chk("lane off", 32'h3b, rd);
    $display("test config finished");
    spi_clk_en <= 1'b1;
    spi_clk_alt <= 1'b1;
    xfer(1'b1, A_C1, 32'h04);
    repeat (3) @(posedge pclk);
    chk("pin_out", 32'hab, {24'h0, pin_out});
    spi_clk_alt <= 1'b0;
    xfer(1'b1, A_C1, 32'h00);
    repeat (3) @(posedge pclk);
    chk("pin_out", 32'ha2, {24'h0, pin_out});
    spi_clk_en <= 1'b0;
    $display("test serial clock finished");
    xfer(1'b1, A_MSK, 32'h1);
    xfer(1'b1, A_EN, 32'h02);
    irq_is(1'b1);
    ext_en <= 8'ha6;
    irq_is(1'b0);
    xfer(1'b1, A_MSK, 32'h0);
    irq_is(1'b1);
    xfer(1'b1, A_MSK, 32'h1);
    irq_is(1'b0);
    xfer(1'b1, A_EN, 32'h00);
    irq_is(1'b1);
    xfer(1'b1, A_C1, 32'h01);
    xfer(1'b1, A_EN, 32'h02);
    irq_is(1'b0);
    xfer(1'b0, A_DATA, '0);
    irq_is(1'b1);
    ext_val <= 8'h26;
    irq_is(1'b0);
    $display("test interrupt finished");
    do_reset();
    xfer(1'b0, A_DMH, '0);
    chk("dm high", 32'hff, rd);
    xfer(1'b0, A_C1, '0);
    chk("cfg one", 32'h00, rd);
    $display("test second reset finished");
    give_verdict();
  end
endmodule : tb
